// file: spipf_monitor.sv
/* Checker of register and pin behaviour of the serial port unit.
   Assumes a bind to spipf_port and one clock domain. */
module spipf_monitor (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [31:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic irq_o,
	input wire logic sck_oe_n_o,
	input wire logic mosi_o,
	input wire logic miso_oe_n_o,
	input wire logic [2:0] select_n_o
);
	logic [6:0] mask_q;
	logic [3:0] ctl_q;
	// Shadow of mask and of static, disable, role, enable bits
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mask_q <= 7'h00;
			ctl_q <= 4'h0;
		end else if (reg_wr_i) begin
			if (reg_addr_i == spipf_pkg::ADDR_IRQ_MASK) mask_q <= reg_wdata_i[6:0];
			if (reg_addr_i == spipf_pkg::ADDR_CTRL_TWO) ctl_q <= {reg_wdata_i[11], reg_wdata_i[3:1]};
		end
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
		else $error("read data outside slot");
	clear_reads_a: assert property (reg_rd_i && reg_addr_i == spipf_pkg::ADDR_IRQ_CLEAR |=> reg_rdata_o == 32'h0)
		else $error("clear register not zero");
	irq_masked_a: assert property (irq_o |-> mask_q != 7'h00) else $error("interrupt with empty mask");
	off_pins_a: assert property (!ctl_q[0] |-> sck_oe_n_o && miso_oe_n_o) else $error("pins driven while off");
	off_mosi_a: assert property (!ctl_q[0] && !$past(ctl_q[0]) |-> !mosi_o) else $error("data out while off");
	master_sck_a: assert property (ctl_q[0] && !ctl_q[1] |-> !sck_oe_n_o)
		else $error("master not driving clock");
	out_disable_a: assert property (ctl_q[2] |-> miso_oe_n_o) else $error("slave output not disabled");
	select_master_a: assert property ($fell(select_n_o[0]) |-> ctl_q[0] && !ctl_q[1])
		else $error("select asserted outside master role");
	cover property ($rose(irq_o));
	cover property ($fell(select_n_o[0]));
	cover property (reg_wr_i && reg_addr_i == spipf_pkg::ADDR_DATA);
endmodule // spipf_monitor
bind spipf_port spipf_monitor mon (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.irq_o(irq_o), .sck_oe_n_o(sck_oe_n_o), .mosi_o(mosi_o), .miso_oe_n_o(miso_oe_n_o), .select_n_o(select_n_o));

// file: spipf_partner.sv
/* Serial device model that echoes the master data while selected.
   Assumes an active-low select from the unit. */
module spipf_partner (
	input wire logic clk_i,
	input wire logic sel_n_i,
	input wire logic mosi_i,
	output logic miso_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last_q = 1'b0;
	// Remember the line level so a released line keeps changing
	always_ff @(posedge clk_i) last_q <= miso_o;
	// Echo while selected, flipping pattern while released
	assign miso_o = sel_n_i ? ~last_q : mosi_i;
endmodule // spipf_partner

// file: spipf_pkg.sv
/*
 * Constants, register layouts and flag groups of the serial port unit
 * with its queues and interrupt sources.
 * Assumes one system clock of 25 MHz and a plain register port.
 */
// Operation
// R01 - Writing one to the receive flush bit empties the receive queue.
// R02 - Receive-level raw interrupt is one while receive count exceeds threshold, threshold resets eight.
// R03 - Transmit-level raw interrupt is one while transmit count is below threshold, reset eight.
// R04 - Transmit flush empties the transmit queue; software idles one clock before new data.
// R05 - Select toggles per frame when not static, else follows programmed select value.
// R06 - Static select with phase zero needs software to toggle select after each frame.
// R07 - Master drives three select bits, inverted because the select format is active low.
// R08 - In slave mode the select field masks which select input counts.
// R09 - Output-disable bit stops the slave from driving its serial output.
// R10 - Role bit zero means master, one means slave.
// R11 - The port works only while its enable bit is one; reset clears it.
// R12 - Loopback feeds serial output back to input; software also enables input filtering.
// R13 - Data read pops the receive queue, write pushes transmit queue; both sixteen deep.
// R14 - Transmit words are right-aligned; received words right-aligned, upper bits zero.
// R15 - Slave fetches next word at last bit out; none and select held flags underrun.
// R16 - Status holds sticky receive/transmit underrun and overflow flags for lost data.
// R17 - Status shows five-bit receive and transmit queue counts.
// R18 - Status shows busy plus receive full, not-empty, transmit not-full and empty.
// R19 - Mask ANDed with raw bits gives masked status; any set bit raises interrupt.
// R20 - Timeout raw sets when receive queue unread for thirty-two serial periods.
// R21 - Writing one to clear register clears that raw bit; state-based ones self-clear.
// R22 - Compatibility raw bits follow transmit empty, receive full and receive not-empty.
// R23 - Word length is field plus one, four to sixteen bits, reset eight bits.
// R24 - Master serial clock equals multiply-add times clock over 4096; zero freezes.
// R25 - Phase picks first or second sampling edge; polarity picks idle-low or idle-high.
// R26 - Receive overrun raw sets on a word arriving at a full queue, sticky.
// R27 - Full transmit writes are dropped with overflow; empty reads give zero with underrun.
package spipf_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int DEPTH = 16;
	localparam int PTR_W = 4;
	localparam int CNT_W = 5;
	localparam int ACC_W = 12;
	localparam int IRQ_W = 7;
	localparam int TO_W = 6;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] ADDR_CTRL_ONE = 32'h1014_0680;
	localparam logic [31:0] ADDR_CTRL_TWO = 32'h1014_0684;
	localparam logic [31:0] ADDR_DATA = 32'h1014_0688;
	localparam logic [31:0] ADDR_STATUS = 32'h1014_068C;
	localparam logic [31:0] ADDR_PRESCALE = 32'h1014_0690;
	localparam logic [31:0] ADDR_IRQ_MASK = 32'h1014_0694;
	localparam logic [31:0] ADDR_IRQ_RAW = 32'h1014_0698;
	localparam logic [31:0] ADDR_IRQ_MASKED = 32'h1014_069C;
	localparam logic [31:0] ADDR_IRQ_CLEAR = 32'h1014_06A0;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [11:0] MULADD_RST = 12'h800;
	localparam logic [3:0] WLEN_RST = 4'h7;
	localparam logic [3:0] WLEN_MIN = 4'h3;
	localparam logic [3:0] RX_THR_RST = 4'h8;
	localparam logic [3:0] TX_THR_RST = 4'h8;
	localparam int TIMEOUT_PERIODS = 32;
	localparam logic [TO_W-1:0] TIMEOUT_CNT = TO_W'(TIMEOUT_PERIODS);

	// ----------------------------------------------------------------
	// Register layouts
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] rsvd_31_28;
		logic input_filter;
		logic [6:0] rsvd_26_20;
		logic [11:0] sck_muladd;
		logic clock_phase;
		logic clock_polarity;
		logic [1:0] rsvd_5_4;
		logic [3:0] word_length_select;
	} spipf_ctrl_one_t;

	typedef struct packed {
		logic [2:0] rsvd_31_29;
		logic rx_queue_flush;
		logic [3:0] rx_queue_threshold;
		logic [2:0] rsvd_23_21;
		logic tx_queue_flush;
		logic [3:0] tx_queue_threshold;
		logic [3:0] rsvd_15_12;
		logic static_select;
		logic [2:0] frame_select;
		logic [3:0] rsvd_7_4;
		logic follower_output_disable;
		logic role_select;
		logic port_enable;
		logic internal_loopback;
	} spipf_ctrl_two_t;

	typedef struct packed {
		logic rx_underrun_flag;
		logic rx_overflow_flag;
		logic rsvd_29;
		logic [4:0] rx_level;
		logic tx_underrun_flag;
		logic tx_overflow_flag;
		logic rsvd_21;
		logic [4:0] tx_level;
		logic [10:0] rsvd_15_5;
		logic transfer_active;
		logic rx_full_flag;
		logic rx_nonempty_flag;
		logic tx_nonfull_flag;
		logic tx_empty_flag;
	} spipf_status_t;

	typedef struct packed {
		logic tx_empty;
		logic rx_full;
		logic rx_nonempty;
		logic tx_level;
		logic rx_level;
		logic rx_timeout;
		logic rx_overrun;
	} spipf_irq_t;

endpackage : spipf_pkg

// file: spipf_port.sv
/*
 * Serial port unit: register port, two sixteen-word queues, master and
 * slave shift engines, select handling and interrupt sources.
 * Assumes all pins are synchronous to ref_clk_i and the register master
 * never issues read and write strobes together.
 */

// ----------------------------------------------------------------
// Word queue
// ----------------------------------------------------------------
module spipf_queue (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic flush_i,
	input wire logic push_i,
	input wire logic [spipf_pkg::WORD_W-1:0] data_i,
	input wire logic pop_i,
	output logic [spipf_pkg::WORD_W-1:0] head_o,
	output logic [spipf_pkg::CNT_W-1:0] count_o,
	output logic full_o,
	output logic empty_o
);
	logic [spipf_pkg::WORD_W-1:0] mem_q [spipf_pkg::DEPTH];
	logic [spipf_pkg::PTR_W-1:0] wr_q;
	logic [spipf_pkg::PTR_W-1:0] rd_q;
	logic [spipf_pkg::CNT_W-1:0] cnt_q;
	logic do_push;
	logic do_pop;

	assign full_o = (cnt_q == spipf_pkg::CNT_W'(spipf_pkg::DEPTH));
	assign empty_o = (cnt_q == '0);
	assign do_push = push_i && !full_o;
	assign do_pop = pop_i && !empty_o;
	assign head_o = mem_q[rd_q];
	assign count_o = cnt_q;

	// Storage, written only on accepted pushes
	always_ff @(posedge clk_i) begin
		if (do_push) begin
			mem_q[wr_q] <= data_i;
		end
	end

	// Pointers and count; flush wins over traffic
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (flush_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (do_push) wr_q <= wr_q + 1'b1;
			if (do_pop) rd_q <= rd_q + 1'b1;
			if (do_push && !do_pop) cnt_q <= cnt_q + 1'b1;
			else if (do_pop && !do_push) cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule // spipf_queue

// ----------------------------------------------------------------
// Port top
// ----------------------------------------------------------------
module spipf_port (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [31:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	output logic irq_o,
	output logic sck_o,
	output logic sck_oe_n_o,
	input wire logic sck_i,
	output logic mosi_o,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_n_o,
	input wire logic miso_i,
	output logic [2:0] select_n_o,
	input wire logic [2:0] select_n_i
);
	typedef enum logic [0:0] {M_IDLE, M_SHIFT} spipf_mstate_t;

	spipf_pkg::spipf_ctrl_one_t ctrl1_q;
	spipf_pkg::spipf_ctrl_two_t ctrl2_q;
	spipf_pkg::spipf_irq_t mask_q;
	spipf_pkg::spipf_irq_t raw;
	spipf_pkg::spipf_status_t status;
	logic [7:0] prescale_q;
	logic [31:0] rdata_q;
	logic rx_flush, tx_flush, wr_data, rd_data, wr_clear;
	logic [spipf_pkg::WORD_W-1:0] tx_head, rx_head;
	logic [spipf_pkg::CNT_W-1:0] tx_cnt, rx_cnt;
	logic tx_full, tx_empty, rx_full, rx_empty;
	logic tx_pop, m_pop, s_pop;
	logic rx_push_q;
	logic [spipf_pkg::WORD_W-1:0] rx_word_q;
	logic rx_err_u_q, rx_err_o_q, tx_err_u_q, tx_err_o_q, overrun_q, timeout_q;
	logic [spipf_pkg::TO_W-1:0] to_cnt_q;
	logic [spipf_pkg::ACC_W-1:0] acc_q;
	logic [spipf_pkg::ACC_W:0] acc_sum;
	logic half_tick, period_tick;
	logic [3:0] len_m1;
	logic master_en, slave_en;
	spipf_mstate_t mstate_q;
	logic sck_q, out_q;
	logic [spipf_pkg::WORD_W-1:0] tx_sh_q, rx_sh_q, rx_next;
	logic [4:0] edge_cnt_q;
	logic m_drive, m_sample, m_last;
	logic [2:0] hist0_q, hist1_q, hist2_q;
	logic [4:0] raw_in, filt_in, maj;
	logic din, sck_f, sel, sel_prev_q, sck_prev_q;
	logic s_edge, s_lead, s_drive, s_sample, have_q;
	logic [3:0] s_dcnt_q, s_scnt_q;

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	assign wr_data = reg_wr_i && (reg_addr_i == spipf_pkg::ADDR_DATA);
	assign rd_data = reg_rd_i && (reg_addr_i == spipf_pkg::ADDR_DATA);
	assign wr_clear = reg_wr_i && (reg_addr_i == spipf_pkg::ADDR_IRQ_CLEAR);
	assign rx_flush = reg_wr_i && (reg_addr_i == spipf_pkg::ADDR_CTRL_TWO) && reg_wdata_i[28]; // [R01]
	assign tx_flush = reg_wr_i && (reg_addr_i == spipf_pkg::ADDR_CTRL_TWO) && reg_wdata_i[20]; // [R04]

	// Control registers; reserved and flush bits always read zero
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl1_q <= '0;
			ctrl1_q.sck_muladd <= spipf_pkg::MULADD_RST; // [R24]
			ctrl1_q.word_length_select <= spipf_pkg::WLEN_RST; // [R23]
			ctrl2_q <= '0; // [R11]
			ctrl2_q.rx_queue_threshold <= spipf_pkg::RX_THR_RST; // [R02]
			ctrl2_q.tx_queue_threshold <= spipf_pkg::TX_THR_RST; // [R03]
			mask_q <= '0;
			prescale_q <= '0;
		end else if (reg_wr_i) begin
			unique case (reg_addr_i)
				spipf_pkg::ADDR_CTRL_ONE: begin
					ctrl1_q <= '0;
					ctrl1_q.input_filter <= reg_wdata_i[27];
					ctrl1_q.sck_muladd <= reg_wdata_i[19:8];
					ctrl1_q.clock_phase <= reg_wdata_i[7];
					ctrl1_q.clock_polarity <= reg_wdata_i[6];
					ctrl1_q.word_length_select <= reg_wdata_i[3:0];
				end
				spipf_pkg::ADDR_CTRL_TWO: begin
					ctrl2_q <= '0;
					ctrl2_q.rx_queue_threshold <= reg_wdata_i[27:24];
					ctrl2_q.tx_queue_threshold <= reg_wdata_i[19:16];
					ctrl2_q.static_select <= reg_wdata_i[11];
					ctrl2_q.frame_select <= reg_wdata_i[10:8];
					ctrl2_q.follower_output_disable <= reg_wdata_i[3];
					ctrl2_q.role_select <= reg_wdata_i[2];
					ctrl2_q.port_enable <= reg_wdata_i[1];
					ctrl2_q.internal_loopback <= reg_wdata_i[0];
				end
				spipf_pkg::ADDR_PRESCALE: prescale_q <= reg_wdata_i[7:0];
				spipf_pkg::ADDR_IRQ_MASK: mask_q <= reg_wdata_i[spipf_pkg::IRQ_W-1:0]; // [R19]
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Queues
	// ----------------------------------------------------------------
	assign tx_pop = m_pop | s_pop;

	spipf_queue u_tx_queue (
		.clk_i(ref_clk_i),
		.rst_i(rst_i),
		.flush_i(tx_flush), // [R04]
		.push_i(wr_data), // [R13]
		.data_i(reg_wdata_i[spipf_pkg::WORD_W-1:0]), // [R14]
		.pop_i(tx_pop),
		.head_o(tx_head),
		.count_o(tx_cnt),
		.full_o(tx_full),
		.empty_o(tx_empty)
	);

	spipf_queue u_rx_queue (
		.clk_i(ref_clk_i),
		.rst_i(rst_i),
		.flush_i(rx_flush), // [R01]
		.push_i(rx_push_q),
		.data_i(rx_word_q),
		.pop_i(rd_data), // [R13]
		.head_o(rx_head),
		.count_o(rx_cnt),
		.full_o(rx_full),
		.empty_o(rx_empty)
	);

	// Sticky error flags; set wins over the flush that clears them
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_err_u_q <= 1'b0;
			rx_err_o_q <= 1'b0;
			tx_err_o_q <= 1'b0;
		end else begin
			rx_err_u_q <= (rd_data && rx_empty) || (rx_err_u_q && !rx_flush); // [R27] [R16]
			rx_err_o_q <= (rx_push_q && rx_full) || (rx_err_o_q && !rx_flush); // [R16]
			tx_err_o_q <= (wr_data && tx_full) || (tx_err_o_q && !tx_flush); // [R27] [R16]
		end
	end

	// ----------------------------------------------------------------
	// Serial clock generator
	// ----------------------------------------------------------------
	assign acc_sum = {1'b0, acc_q} + {1'b0, ctrl1_q.sck_muladd}; // [R24]
	assign half_tick = acc_sum[spipf_pkg::ACC_W-1] ^ acc_q[spipf_pkg::ACC_W-1];
	assign period_tick = acc_sum[spipf_pkg::ACC_W];
	assign len_m1 = (ctrl1_q.word_length_select < spipf_pkg::WLEN_MIN) ?
		spipf_pkg::WLEN_MIN : ctrl1_q.word_length_select; // [R23]
	assign master_en = ctrl2_q.port_enable && !ctrl2_q.role_select; // [R10] [R11]
	assign slave_en = ctrl2_q.port_enable && ctrl2_q.role_select; // [R10] [R11]

	// Phase accumulator; a zero step freezes every edge
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) acc_q <= '0;
		else acc_q <= acc_sum[spipf_pkg::ACC_W-1:0];
	end

	// ----------------------------------------------------------------
	// Input filter and loopback
	// ----------------------------------------------------------------
	assign raw_in = {sck_i, select_n_i,
		ctrl2_q.internal_loopback ? out_q : (ctrl2_q.role_select ? mosi_i : miso_i)}; // [R12]

	// Three-sample history per input
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hist0_q <= '1;
			hist1_q <= '1;
			hist2_q <= '1;
		end else begin
			hist0_q <= {hist0_q[1:0], raw_in[0]};
			hist1_q <= {hist1_q[1:0], raw_in[4]};
			hist2_q <= {hist2_q[1:0], |(~raw_in[3:1] & ctrl2_q.frame_select)}; // [R08]
		end
	end

	assign maj[0] = (hist0_q[0] & hist0_q[1]) | (hist0_q[0] & hist0_q[2]) | (hist0_q[1] & hist0_q[2]);
	assign maj[1] = (hist1_q[0] & hist1_q[1]) | (hist1_q[0] & hist1_q[2]) | (hist1_q[1] & hist1_q[2]);
	assign maj[2] = (hist2_q[0] & hist2_q[1]) | (hist2_q[0] & hist2_q[2]) | (hist2_q[1] & hist2_q[2]);
	assign maj[4:3] = '0;
	assign filt_in[0] = ctrl1_q.input_filter ? maj[0] : raw_in[0];
	assign filt_in[1] = ctrl1_q.input_filter ? maj[1] : raw_in[4];
	assign filt_in[2] = ctrl1_q.input_filter ? maj[2] : |(~raw_in[3:1] & ctrl2_q.frame_select); // [R08]
	assign filt_in[4:3] = '0;
	assign din = filt_in[0];
	assign sck_f = filt_in[1];
	assign sel = slave_en && filt_in[2];

	// ----------------------------------------------------------------
	// Master engine
	// ----------------------------------------------------------------
	assign m_drive = (mstate_q == M_SHIFT) && half_tick && (edge_cnt_q[0] != ctrl1_q.clock_phase); // [R25]
	assign m_sample = (mstate_q == M_SHIFT) && half_tick && (edge_cnt_q[0] == ctrl1_q.clock_phase); // [R25]
	assign m_last = (edge_cnt_q == {len_m1, 1'b1});
	assign m_pop = (mstate_q == M_IDLE) && master_en && !tx_empty && half_tick; // [R24]
	assign rx_next = {rx_sh_q[spipf_pkg::WORD_W-2:0], din};

	// Frame sequencing, clock output and edge counting in master role
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mstate_q <= M_IDLE;
			sck_q <= 1'b0;
			edge_cnt_q <= '0;
		end else begin
			unique case (mstate_q)
				M_IDLE: begin
					sck_q <= ctrl1_q.clock_polarity; // [R25]
					edge_cnt_q <= '0;
					if (m_pop) mstate_q <= M_SHIFT;
				end
				M_SHIFT: begin
					if (!master_en) begin
						mstate_q <= M_IDLE; // [R11]
					end else if (half_tick) begin
						sck_q <= ~sck_q;
						edge_cnt_q <= edge_cnt_q + 1'b1;
						if (m_last) mstate_q <= M_IDLE; // [R05]
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Slave engine
	// ----------------------------------------------------------------
	assign s_edge = sel && sel_prev_q && (sck_f != sck_prev_q);
	assign s_lead = (sck_f != ctrl1_q.clock_polarity);
	assign s_drive = s_edge && (s_lead == ctrl1_q.clock_phase); // [R25]
	assign s_sample = s_edge && (s_lead != ctrl1_q.clock_phase); // [R25]
	assign s_pop = ((sel && !sel_prev_q) || (s_drive && s_dcnt_q == len_m1)) && !tx_empty; // [R15]

	// Edge history and bit counters in slave role
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sel_prev_q <= 1'b0;
			sck_prev_q <= 1'b0;
			s_dcnt_q <= '0;
			s_scnt_q <= '0;
			have_q <= 1'b0;
			tx_err_u_q <= 1'b0;
		end else begin
			sel_prev_q <= sel;
			sck_prev_q <= sck_f;
			tx_err_u_q <= (s_edge && !have_q) || (tx_err_u_q && !tx_flush); // [R15] [R16]
			if (!sel) begin
				s_dcnt_q <= '0;
				s_scnt_q <= '0;
				have_q <= 1'b0;
			end else begin
				if (!sel_prev_q) have_q <= !tx_empty;
				if (s_drive) begin
					s_dcnt_q <= (s_dcnt_q == len_m1) ? '0 : s_dcnt_q + 1'b1;
					if (s_dcnt_q == len_m1) have_q <= !tx_empty; // [R15]
				end
				if (s_sample) s_scnt_q <= (s_scnt_q == len_m1) ? '0 : s_scnt_q + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Shared shift registers and receive hand-off
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_sh_q <= '0;
			rx_sh_q <= '0;
			out_q <= 1'b0;
			rx_push_q <= 1'b0;
			rx_word_q <= '0;
		end else begin
			rx_push_q <= 1'b0;
			if (m_pop || (sel && !sel_prev_q)) begin
				rx_sh_q <= '0; // [R14]
				if (ctrl1_q.clock_phase) begin
					tx_sh_q <= tx_empty ? '0 : tx_head;
				end else begin
					out_q <= tx_empty ? 1'b0 : tx_head[len_m1]; // [R14]
					tx_sh_q <= tx_empty ? '0 : (tx_head << 1);
				end
			end else begin
				if (m_drive || s_drive) begin
					out_q <= (s_drive && !have_q) ? 1'b0 : tx_sh_q[len_m1]; // [R14]
					tx_sh_q <= tx_sh_q << 1;
					if (s_drive && s_dcnt_q == len_m1) tx_sh_q <= tx_empty ? '0 : tx_head; // [R15]
				end
				if (m_sample || s_sample) rx_sh_q <= rx_next;
				if (s_sample && s_scnt_q == len_m1) begin
					rx_push_q <= 1'b1;
					rx_word_q <= rx_next;
					rx_sh_q <= '0;
				end
				if ((mstate_q == M_SHIFT) && half_tick && m_last) begin
					rx_push_q <= 1'b1;
					rx_word_q <= m_sample ? rx_next : rx_sh_q;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Pins
	// ----------------------------------------------------------------
	assign sck_o = sck_q;
	assign sck_oe_n_o = !master_en;
	assign mosi_o = master_en ? out_q : 1'b0;
	assign miso_o = out_q;
	assign miso_oe_n_o = !(sel && !ctrl2_q.follower_output_disable); // [R09]
	assign select_n_o = (master_en && (ctrl2_q.static_select || mstate_q == M_SHIFT)) ?
		~ctrl2_q.frame_select : '1; // [R05] [R07]

	// ----------------------------------------------------------------
	// Interrupt sources
	// ----------------------------------------------------------------
	// Timeout counter over serial periods while unread data waits
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			to_cnt_q <= '0;
			timeout_q <= 1'b0;
			overrun_q <= 1'b0;
		end else begin
			overrun_q <= (rx_push_q && rx_full) || (overrun_q && !(wr_clear && reg_wdata_i[0])); // [R26] [R21]
			if (rx_empty || rd_data || (wr_clear && reg_wdata_i[1])) begin
				to_cnt_q <= '0; // [R20] [R21]
				timeout_q <= 1'b0;
			end else if (period_tick && to_cnt_q != spipf_pkg::TIMEOUT_CNT) begin
				to_cnt_q <= to_cnt_q + 1'b1;
				if (to_cnt_q == spipf_pkg::TIMEOUT_CNT - 1'b1) timeout_q <= 1'b1; // [R20]
			end
		end
	end

	assign raw.tx_empty = tx_empty; // [R22]
	assign raw.rx_full = rx_full; // [R22]
	assign raw.rx_nonempty = !rx_empty; // [R22]
	assign raw.tx_level = (tx_cnt < {1'b0, ctrl2_q.tx_queue_threshold}); // [R03]
	assign raw.rx_level = (rx_cnt > {1'b0, ctrl2_q.rx_queue_threshold}); // [R02]
	assign raw.rx_timeout = timeout_q;
	assign raw.rx_overrun = overrun_q;
	assign irq_o = |(raw & mask_q); // [R19]

	// ----------------------------------------------------------------
	// Status and read data
	// ----------------------------------------------------------------
	always_comb begin
		status = '0;
		status.rx_underrun_flag = rx_err_u_q; // [R16]
		status.rx_overflow_flag = rx_err_o_q;
		status.rx_level = rx_cnt; // [R17]
		status.tx_underrun_flag = tx_err_u_q;
		status.tx_overflow_flag = tx_err_o_q;
		status.tx_level = tx_cnt; // [R17]
		status.transfer_active = (mstate_q == M_SHIFT) || sel || !tx_empty; // [R18]
		status.rx_full_flag = rx_full; // [R18]
		status.rx_nonempty_flag = !rx_empty;
		status.tx_nonfull_flag = !tx_full;
		status.tx_empty_flag = tx_empty;
	end

	// Read data stands in the cycle after the strobe only
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= '0;
			if (reg_rd_i) begin
				unique case (reg_addr_i)
					spipf_pkg::ADDR_CTRL_ONE: rdata_q <= ctrl1_q;
					spipf_pkg::ADDR_CTRL_TWO: rdata_q <= ctrl2_q;
					spipf_pkg::ADDR_DATA: rdata_q <= rx_empty ? '0 : {16'h0000, rx_head}; // [R13] [R27]
					spipf_pkg::ADDR_STATUS: rdata_q <= status;
					spipf_pkg::ADDR_PRESCALE: rdata_q <= {24'h000000, prescale_q};
					spipf_pkg::ADDR_IRQ_MASK: rdata_q <= {25'h0000000, mask_q};
					spipf_pkg::ADDR_IRQ_RAW: rdata_q <= {25'h0000000, raw};
					spipf_pkg::ADDR_IRQ_MASKED: rdata_q <= {25'h0000000, raw & mask_q}; // [R19]
					default: rdata_q <= '0;
				endcase
			end
		end
	end

	assign reg_rdata_o = rdata_q;
endmodule // spipf_port

// file: spipf_port_tb.sv
/* Self-checking bench of the serial port unit.
   Assumes the echo partner on the master data lines. */
module spipf_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, irq, sck, mosi, miso;
	logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, v, w;
	logic [2:0] sel_n;
	int err_total = 0, num_checks = 0, seed = 32'hB050FD12;
	spipf_port dut (.ref_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq), .sck_o(sck), .sck_oe_n_o(), .sck_i(sck), .mosi_o(mosi),
		.mosi_i(mosi), .miso_o(), .miso_oe_n_o(), .miso_i(miso), .select_n_o(sel_n), .select_n_i(3'h7));
	spipf_partner peer (.clk_i(clk), .sel_n_i(sel_n[0]), .mosi_i(mosi), .miso_o(miso));
	// Status value of an idle unit with no error flags
	function automatic logic [31:0] f_stat(input int rx, tx);
		return {3'h0, 5'(rx), 3'h0, 5'(tx), 11'h0, tx != 0, rx == 16, rx != 0, tx != 16, tx == 0};
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [31:0] a, d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [31:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rchk(input logic [31:0] a, exp);
		rreg(a, v);
		chk(v, exp);
	endtask
	// ----------------------------------------------------------------
	// Clock and main sequence
	// ----------------------------------------------------------------
	initial forever #20 clk = ~clk;
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rchk(spipf_pkg::ADDR_CTRL_TWO, 32'h0808_0000);
		rchk(spipf_pkg::ADDR_STATUS, f_stat(0, 0));
		rchk(spipf_pkg::ADDR_IRQ_RAW, 32'h48);
		rchk(32'h1014_06A4, 32'h0);
		rchk(spipf_pkg::ADDR_DATA, 32'h0);
		rchk(spipf_pkg::ADDR_STATUS, f_stat(0, 0) | 32'h8000_0000);
		wreg(spipf_pkg::ADDR_CTRL_TWO, 32'h1808_0000);
		rchk(spipf_pkg::ADDR_STATUS, f_stat(0, 0));
		$display("test reset and underrun done");
		for (int i = 0; i < 17; i++) wreg(spipf_pkg::ADDR_DATA, 32'(i));
		rchk(spipf_pkg::ADDR_STATUS, f_stat(0, 16) | 32'h0040_0000);
		rchk(spipf_pkg::ADDR_IRQ_RAW, 32'h0);
		wreg(spipf_pkg::ADDR_CTRL_TWO, 32'h0818_0000);
		rchk(spipf_pkg::ADDR_STATUS, f_stat(0, 0));
		wreg(spipf_pkg::ADDR_IRQ_MASK, 32'h40);
		#1 chk({31'h0, irq}, 32'h1);
		rchk(spipf_pkg::ADDR_IRQ_MASKED, 32'h40);
		wreg(spipf_pkg::ADDR_IRQ_MASK, 32'h04);
		#1 chk({31'h0, irq}, 32'h0);
		$display("test queue and interrupt done");
		wreg(spipf_pkg::ADDR_CTRL_TWO, 32'h0808_010A);
		for (int k = 0; k < 3; k++) begin
			w = (k == 0) ? 32'hFFFF : $random(seed);
			wreg(spipf_pkg::ADDR_CTRL_ONE, {12'h000, 12'h800, 2'(k), 2'h0, 4'(7 + 4 * k)});
			wreg(spipf_pkg::ADDR_DATA, w);
			v = 32'h0;
			for (int t = 0; t < 100 && v[28:24] == 5'h0; t++) rreg(spipf_pkg::ADDR_STATUS, v);
			if (v[28:24] == 5'h0) begin
				err_total++;
				$display("mismatch at %0t: no word received", $time);
				conclude();
			end
			rchk(spipf_pkg::ADDR_DATA, w & ((32'h1 << (8 + 4 * k)) - 32'h1));
			chk({31'h0, sck}, 32'(k % 2));
		end
		$display("test traffic done");
		conclude();
	end
endmodule // spipf_port_tb
